// >>> src/tpr_rgb_port.sv
`timescale 1ns/1ps
`include "tpr_regs.svh"

module tpr_rgb_port
  import tpr_pkg::*;
#(
  parameter int H_ACTIVE = `TPR_H_ACTIVE,
  parameter int V_ACTIVE = `TPR_V_ACTIVE
) (
  input wire logic sys_clk, // Pixel sample clock
  input wire logic rst_n, // Async reset, active low
  input wire logic hsync_n, // Horizontal sync, active low
  input wire logic vsync_n, // Vertical sync, active low
  input wire logic active_video_enable, // Data enable, active high
  input wire logic [`TPR_CHAN_W-1:0] red_channel_bits, // Red, bit 0 is LSB
  input wire logic [`TPR_CHAN_W-1:0] green_channel_bits, // Green, bit 0 is LSB
  input wire logic [`TPR_CHAN_W-1:0] blue_channel_bits, // Blue, bit 0 is LSB
  input wire logic hdir_mirror, // High: mirror left and right
  input wire logic vdir_normal, // High: normal top to bottom
  output logic pix_valid_q, // Pixel write strobe
  output tpr_pos_t pix_pos_q, // Panel position of the pixel
  output tpr_pixel_t pix_rgb_q, // Pixel colour
  output logic line_start_q, // First pixel of a visible line
  output logic frame_start_q, // First visible line reached
  output logic hstart_err_q, // Data enable rose off its fixed offset
  output logic de_missing_q // Visible line ended without data enable
);

  // Refused at elaboration, so an axis too wide for its counter never builds
  if (H_ACTIVE < 1 || H_ACTIVE > (1 << `TPR_X_W)) begin : h_size_chk
    $error("H_ACTIVE out of range");
  end
  if (V_ACTIVE < 1 || V_ACTIVE > (1 << `TPR_Y_W)) begin : v_size_chk
    $error("V_ACTIVE out of range");
  end

  localparam logic [`TPR_X_W-1:0] XLAST = `TPR_X_W'(H_ACTIVE - 1);
  localparam logic [`TPR_Y_W-1:0] YLAST = `TPR_Y_W'(V_ACTIVE - 1);
  localparam logic [`TPR_LINE_W-1:0] VOFS = `TPR_LINE_W'(`TPR_FRAME_START_OFFSET);
  localparam logic [`TPR_LINE_W-1:0] VEND = `TPR_LINE_W'(`TPR_FRAME_START_OFFSET + V_ACTIVE);
  localparam logic [`TPR_HCNT_W-1:0] HOFS = `TPR_HCNT_W'(`TPR_HSTART_OFFSET);

  // Reflects an index about the last position of its axis
  function automatic logic [`TPR_LINE_W-1:0] flip_idx(input logic [`TPR_LINE_W-1:0] idx,
                                                     input logic [`TPR_LINE_W-1:0] last);
    flip_idx = last - idx;
  endfunction

  tpr_vstate_t state_q, state_d;
  logic hs_prev_q, hs_prev_d, vs_prev_q, vs_prev_d, de_prev_q, de_prev_d;
  logic de_seen_q, de_seen_d;
  logic [`TPR_LINE_W-1:0] line_q, line_d;
  logic [`TPR_X_W-1:0] col_q, col_d;
  logic [`TPR_HCNT_W-1:0] hcnt_q, hcnt_d;
  logic pix_valid_d, line_start_d, frame_start_d, hstart_err_d, de_missing_d;
  tpr_pos_t pix_pos_d;
  tpr_pixel_t pix_rgb_d;
  logic hs_fall, vs_fall, de_rise;
  logic [`TPR_X_W-1:0] col_cur;
  logic [`TPR_LINE_W-1:0] row;
  logic [`TPR_LINE_W-1:0] x_flip, y_flip;

  always_comb begin
    hs_fall = hs_prev_q & ~hsync_n;
    vs_fall = vs_prev_q & ~vsync_n;
    de_rise = active_video_enable & ~de_prev_q;
    hs_prev_d = hsync_n;
    vs_prev_d = vsync_n;
    de_prev_d = active_video_enable;
    state_d = state_q;
    line_d = line_q;
    hcnt_d = hcnt_q;
    de_missing_d = 1'b0;
    frame_start_d = 1'b0;
    de_seen_d = de_seen_q;
    // Line position counts only sync edges, so a late or missing enable cannot shift rows
    if (vs_fall) begin
      state_d = TPR_VBLANK;
      line_d = '0;
    end else if (hs_fall) begin
      if (line_q != '1)
        line_d = line_q + `TPR_LINE_W'(1);
      case (state_q)
        TPR_VBLANK: begin
          if (line_d == VOFS) begin
            state_d = TPR_VACTIVE;
            frame_start_d = 1'b1;
          end
        end
        TPR_VACTIVE: begin
          if (line_d == VEND)
            state_d = TPR_WAIT_VS;
        end
        TPR_WAIT_VS: state_d = TPR_WAIT_VS;
        default: state_d = TPR_WAIT_VS;
      endcase
    end
    if (hs_fall) begin
      hcnt_d = `TPR_HCNT_W'(1);
      // Any visible line, the first included, that closes with no enable rise is flagged
      de_missing_d = (state_q == TPR_VACTIVE) && !de_seen_q;
      de_seen_d = 1'b0;
    end else if (hcnt_q != '1) begin
      hcnt_d = hcnt_q + `TPR_HCNT_W'(1);
    end
    // Set wins over the clear when enable rises in a sync cycle
    if (de_rise)
      de_seen_d = 1'b1;
    hstart_err_d = de_rise && !hs_fall && hcnt_q != HOFS;
    col_cur = de_rise ? '0 : col_q;
    col_d = col_q;
    if (active_video_enable && col_cur <= XLAST)
      col_d = col_cur + `TPR_X_W'(1);
    else if (de_rise)
      col_d = col_cur;
    row = line_q - VOFS;
    pix_valid_d = active_video_enable && (state_q == TPR_VACTIVE) && (col_cur <= XLAST);
    line_start_d = pix_valid_d && de_rise;
    // Mirrored indices are worked at line width, then cut to the axis width
    x_flip = flip_idx({1'b0, col_cur}, {1'b0, XLAST});
    y_flip = flip_idx(row, {2'b00, YLAST});
    pix_pos_d.x = hdir_mirror ? x_flip[`TPR_X_W-1:0] : col_cur;
    pix_pos_d.y = vdir_normal ? row[`TPR_Y_W-1:0] : y_flip[`TPR_Y_W-1:0];
    pix_rgb_d.red = red_channel_bits;
    pix_rgb_d.green = green_channel_bits;
    pix_rgb_d.blue = blue_channel_bits;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TPR_WAIT_VS;
      hs_prev_q <= 1'b1;
      vs_prev_q <= 1'b1;
      de_prev_q <= 1'b0;
      de_seen_q <= 1'b0;
      line_q <= '0;
      col_q <= '0;
      hcnt_q <= '1;
      pix_valid_q <= 1'b0;
      pix_pos_q <= '0;
      pix_rgb_q <= '0;
      line_start_q <= 1'b0;
      frame_start_q <= 1'b0;
      hstart_err_q <= 1'b0;
      de_missing_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hs_prev_q <= hs_prev_d;
      vs_prev_q <= vs_prev_d;
      de_prev_q <= de_prev_d;
      de_seen_q <= de_seen_d;
      line_q <= line_d;
      col_q <= col_d;
      hcnt_q <= hcnt_d;
      pix_valid_q <= pix_valid_d;
      pix_pos_q <= pix_pos_d;
      pix_rgb_q <= pix_rgb_d;
      line_start_q <= line_start_d;
      frame_start_q <= frame_start_d;
      hstart_err_q <= hstart_err_d;
      de_missing_q <= de_missing_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence hs_edge_s;
    hs_fall;
  endsequence

  sequence de_on_time_s;
    (!hs_fall && !de_rise) [*6] ##1 (de_rise && !hs_fall);
  endsequence

  valid_needs_enable_a: assert property (pix_valid_q |-> $past(active_video_enable))
    else $error("pixel strobe without data enable");
  colour_sampled_a: assert property (pix_valid_q |-> pix_rgb_q == {$past(red_channel_bits),
    $past(green_channel_bits), $past(blue_channel_bits)})
    else $error("pixel colour differs from sampled lines");
  line_start_col_a: assert property (line_start_q |-> pix_valid_q &&
    pix_pos_q.x == ($past(hdir_mirror) ? XLAST : '0))
    else $error("line start not at first column");
  hmirror_step_a: assert property (pix_valid_q && !line_start_q && $past(pix_valid_q)
    && $stable(hdir_mirror) |-> pix_pos_q.x == ($past(hdir_mirror, 2) ? $past(pix_pos_q.x) - 1'b1
    : $past(pix_pos_q.x) + 1'b1))
    else $error("column does not step in scan direction");
  vflip_row_a: assert property (pix_valid_q |-> pix_pos_q.y == ($past(vdir_normal)
    ? `TPR_Y_W'($past(line_q) - VOFS) : `TPR_Y_W'(YLAST - `TPR_Y_W'($past(line_q) - VOFS))))
    else $error("row does not follow scan direction");
  frame_offset_a: assert property (frame_start_q |-> line_q == VOFS && state_q == TPR_VACTIVE)
    else $error("visible frame did not start at offset line");
  vsync_only_a: assert property (state_q != TPR_VACTIVE |=> !pix_valid_q)
    else $error("pixel outside visible lines");
  vsync_reset_a: assert property (vs_fall |=> line_q == '0 && state_q == TPR_VBLANK)
    else $error("vertical sync did not restart line count");
  hstart_ok_a: assert property (hs_edge_s ##1 de_on_time_s |=> !hstart_err_q)
    else $error("on-time enable flagged as misplaced");
  hstart_late_a: assert property (hs_edge_s ##1 (!hs_fall && !de_rise) [*7] ##1 (de_rise && !hs_fall)
    |=> hstart_err_q)
    else $error("late enable not flagged");
  de_missing_a: assert property (de_missing_q |-> $past(hs_fall) && !$past(de_seen_q))
    else $error("missing enable flagged wrongly");

  // Checks that the missing flag, frame start and line start fire when due, frame start lasts one cycle, start error needs an enable rise
  sequence visible_close_s;
    hs_fall && !vs_fall && state_q == TPR_VACTIVE;
  endsequence

  missing_set_a: assert property (visible_close_s ##0 !de_seen_q |=> de_missing_q)
    else $error("visible line without enable not flagged");
  frame_start_set_a: assert property (hs_fall && !vs_fall && state_q == TPR_VBLANK
    && line_q == VOFS - `TPR_LINE_W'(1) |=> frame_start_q && state_q == TPR_VACTIVE)
    else $error("seventh line did not open the frame");
  line_start_rise_a: assert property (de_rise && state_q == TPR_VACTIVE |=> pix_valid_q && line_start_q)
    else $error("enable rise did not start a visible line");
  frame_start_once_a: assert property (frame_start_q |=> !frame_start_q)
    else $error("frame start longer than one cycle");
  hstart_cause_a: assert property (hstart_err_q |-> $past(de_rise))
    else $error("start error without enable rise");

endmodule // tpr_rgb_port

// >>> src/tpr_regs.svh
// Overview of operation
// - Every colour line and timing input is sampled on each clock, one pixel per clock.
// - A rising data enable marks horizontal pixel zero of the line.
// - Horizontal direction input low scans normally, high mirrors left and right.
// - Vertical direction input high scans normally, low flips top and bottom.
// - Each pixel carries three 6-bit channels, bit 0 least significant, 320 by 240.
// - The visible frame starts on the seventh line after vertical sync.
// - Vertical position follows the sync edges only; data enable does not affect it.
`ifndef TPR_REGS_SVH
`define TPR_REGS_SVH

`define TPR_CHAN_W 6
`define TPR_H_ACTIVE 320
`define TPR_V_ACTIVE 240
`define TPR_FRAME_START_OFFSET 7
`define TPR_HSTART_OFFSET 7
`define TPR_X_W 9
`define TPR_Y_W 8
`define TPR_LINE_W 10
`define TPR_HCNT_W 4

`endif

// >>> src/tpr_pkg.sv
`include "tpr_regs.svh"

package tpr_pkg;

  typedef struct packed {
    logic [`TPR_CHAN_W-1:0] red;
    logic [`TPR_CHAN_W-1:0] green;
    logic [`TPR_CHAN_W-1:0] blue;
  } tpr_pixel_t;

  typedef struct packed {
    logic [`TPR_X_W-1:0] x;
    logic [`TPR_Y_W-1:0] y;
  } tpr_pos_t;

  typedef enum logic [2:0] {
    TPR_WAIT_VS = 3'h1,
    TPR_VBLANK = 3'h2,
    TPR_VACTIVE = 3'h4
  } tpr_vstate_t;

endpackage

// >>> verif/tpr_ctrl_model.sv
`timescale 1ns/1ps
module tpr_ctrl_model
  import tpr_pkg::*;
(
  input wire logic sys_clk, // Pixel sample clock
  output logic hsync_n, // Horizontal sync, idles high
  output logic vsync_n, // Vertical sync, idles high
  output logic active_video_enable, // Data enable, active high
  output tpr_pixel_t pix // Colour lines
);
  logic [8:0] pc = 9'h000;
  logic [5:0] fr = 6'h00;
  initial begin
    hsync_n = 1'h1;
    vsync_n = 1'h1;
    active_video_enable = 1'h0;
  end
  always @(posedge sys_clk) begin
    pc <= active_video_enable ? pc + 9'h001 : 9'h000;
    fr <= fr + 6'h01;
  end
  // Outside enable the lines keep toggling, so a stale colour never passes for a pixel
  always_comb pix = active_video_enable ? {pc[5:0], pc[8:3], ~pc[5:0]} : {fr, ~fr, fr};
  task automatic vsync_pulse();
    @(posedge sys_clk) vsync_n <= 1'h0;
    @(posedge sys_clk) vsync_n <= 1'h1;
  endtask
  // Off counts clocks from the hsync fall to the enable rise; en low drops enable for the line
  task automatic send_line(input int off, input logic en);
    @(posedge sys_clk) hsync_n <= 1'h0;
    @(posedge sys_clk) hsync_n <= 1'h1;
    repeat (off - 1) @(posedge sys_clk);
    active_video_enable <= en;
    repeat (320) @(posedge sys_clk);
    active_video_enable <= 1'h0;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule // tpr_ctrl_model

// >>> verif/tpr_rgb_port_bench.sv
`timescale 1ns/1ps
module tpr_rgb_port_bench
  import tpr_pkg::*;
  ;
  typedef struct packed {logic mir; logic nrm; logic [8:0] x0; logic [7:0] y0;} tpr_row_t;
  logic sys_clk = 1'h0, rst_n = 1'h0, hdir_mirror = 1'h0, vdir_normal = 1'h1;
  logic hsync_n, vsync_n, de, pix_valid_q, line_start_q, frame_start_q, hstart_err_q, de_missing_q;
  tpr_pixel_t pix, pix_rgb_q, rgb0, rgb1;
  tpr_pos_t pix_pos_q, pos0, pos1;
  int err_count, check_count, n_pix, n_ls, n_frm, n_herr, n_miss;
  tpr_row_t rows [4] = '{'{1'h0, 1'h1, 9'h000, 8'h00}, '{1'h1, 1'h1, 9'h13F, 8'h00},
    '{1'h0, 1'h0, 9'h000, 8'hEF}, '{1'h1, 1'h0, 9'h13F, 8'hEF}};
  tpr_ctrl_model ctrl (.sys_clk(sys_clk), .hsync_n(hsync_n), .vsync_n(vsync_n),
    .active_video_enable(de), .pix(pix));
  tpr_rgb_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .hsync_n(hsync_n), .vsync_n(vsync_n),
    .active_video_enable(de), .red_channel_bits(pix.red), .green_channel_bits(pix.green),
    .blue_channel_bits(pix.blue), .hdir_mirror(hdir_mirror), .vdir_normal(vdir_normal),
    .pix_valid_q(pix_valid_q), .pix_pos_q(pix_pos_q), .pix_rgb_q(pix_rgb_q), .line_start_q(line_start_q),
    .frame_start_q(frame_start_q), .hstart_err_q(hstart_err_q), .de_missing_q(de_missing_q));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (pix_valid_q === 1'h1) begin
      if (n_pix == 0) begin
        pos0 = pix_pos_q;
        rgb0 = pix_rgb_q;
      end
      pos1 = pix_pos_q;
      rgb1 = pix_rgb_q;
      n_pix++;
      n_ls += (line_start_q === 1'h1);
    end
    n_frm += (frame_start_q === 1'h1);
    n_herr += (hstart_err_q === 1'h1);
    n_miss += (de_missing_q === 1'h1);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic start(input logic mir, input logic nrm);
    @(posedge sys_clk);
    hdir_mirror <= mir;
    vdir_normal <= nrm;
    #1 {n_pix, n_ls, n_frm, n_herr, n_miss} = '0;
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      start(rows[i].mir, rows[i].nrm);
      ctrl.vsync_pulse();
      repeat (7) ctrl.send_line(7, 1'h1);
      settle();
      check("frame_start", n_frm, 1);
      check("pixels", n_pix, 320);
      check("line_start", n_ls, 1);
      check("first_x", pos0.x, rows[i].x0);
      check("last_x", pos1.x, rows[i].x0 ^ 9'h13F);
      check("first_y", pos0.y, rows[i].y0);
      check("first_rgb", rgb0, 18'h0003F);
      check("last_rgb", rgb1, 18'h3F9C0);
      check("flags", n_herr + n_miss, 0);
      $display("test direction row %0d done", i);
    end
    // A visible line without enable still moves the row on
    start(1'h0, 1'h1);
    ctrl.vsync_pulse();
    repeat (6) ctrl.send_line(7, 1'h1);
    ctrl.send_line(7, 1'h0);
    ctrl.send_line(7, 1'h1);
    ctrl.send_line(8, 1'h1);
    ctrl.send_line(6, 1'h1);
    settle();
    check("de_missing", n_miss, 1);
    check("row_after_gap", pos0.y, 8'h01);
    check("hstart_err", n_herr, 2);
    $display("test enable faults done");
    fork
      ctrl.send_line(7, 1'h1);
      begin
        repeat (100) @(posedge sys_clk);
        rst_n <= 1'h0;
        #1 check("valid_in_reset", pix_valid_q, 1'h0);
        check("pos_in_reset", pix_pos_q, 17'h00000);
      end
    join
    start(1'h0, 1'h1);
    rst_n <= 1'h1;
    ctrl.send_line(7, 1'h1);
    settle();
    check("no_vsync_no_pixels", n_pix, 0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule // tpr_rgb_port_bench
